//--- hdl/pci_port_pkg.sv
// Shared constants for the PCI host-side port and its far end.
package pci_port_pkg;
   localparam int AD_W       = 32;
   localparam int CBE_W      = 4;
   localparam int NUM_REQ    = 5;
   localparam logic [3:0] CMD_MEM_READ  = 4'h6;
   localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
   localparam logic [31:0] DRAM_BASE    = 32'h0000_0000;
   localparam logic [31:0] DRAM_LIMIT   = 32'h0fff_ffff;
   localparam logic [3:0] DRAIN_CYCLES  = 4'h4;
   localparam logic [3:0] CLKRUN_HOLD   = 4'h8;
   localparam logic [2:0] ABORT_WAIT    = 3'h4;

   function automatic logic even_par(input logic [31:0] ad,
                                     input logic [3:0] cbe);
      return ^{ad, cbe};
   endfunction
endpackage

//--- hdl/pci_link_if.sv
// PCI link signals between the host-side port and its far-end agent.
`timescale 1ns/1ps
interface pci_link_if;
   logic [31:0] ad_host, ad_far;
   logic        ad_host_oe, ad_far_oe;
   logic [3:0]  cbe_far;
   logic        cbe_far_oe;
   logic        frame_n, irdy_n, far_oe;
   logic        devsel_n, trdy_n, stop_n, tgt_oe;
   logic        lock_n;
   logic        par_host, par_host_oe, par_far, par_far_oe;
   logic [4:0]  req_n;
   logic [4:0]  master_grant_n;
   logic        bridge_hold_req_n;
   logic        bridge_hold_ack_n;
   logic        serr_n, serr_oe;
   logic        clkrun_host_oe, clkrun_far_oe;
   logic        clkrun_n;

   wire [31:0] ad = ad_host_oe ? ad_host : ad_far;
   wire        par = par_host_oe ? par_host : par_far;
   assign clkrun_n = ~(clkrun_host_oe | clkrun_far_oe);

   modport host (input ad_far, cbe_far, frame_n, irdy_n, lock_n, par_far,
      req_n, bridge_hold_req_n, clkrun_n, output ad_host, ad_host_oe,
      devsel_n, trdy_n, stop_n, tgt_oe, par_host, par_host_oe,
      master_grant_n, bridge_hold_ack_n, serr_n, serr_oe, clkrun_host_oe);
   modport far (input ad_host, devsel_n, trdy_n, stop_n, tgt_oe, par_host,
      master_grant_n, bridge_hold_ack_n, serr_n, clkrun_n,
      output ad_far, ad_far_oe, cbe_far, cbe_far_oe, frame_n, irdy_n,
      far_oe, lock_n, par_far, par_far_oe, req_n, bridge_hold_req_n,
      clkrun_far_oe);
endinterface

//--- hdl/pci_far_agent.sv
// Far end: one PCI initiator plus the expansion bridge hold handshake.
`timescale 1ns/1ps
module pci_far_agent
   import pci_port_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   input  wire logic        start,
   input  wire logic        write,
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  byte_en,
   input  wire logic        hold_want,
   input  wire logic        lock_want,
   input  wire logic        par_flip,
   output logic             done,
   output logic             aborted,
   output logic [31:0]      rdata,
   output logic             hold_owned,
   pci_link_if.far          link
);
   typedef enum logic [2:0] {F_IDLE, F_REQ, F_ADDR, F_DATA, F_TURN} far_e;
   far_e state_reg;
   logic [31:0] ad_reg;
   logic [3:0]  cbe_reg;
   logic        frame_reg, irdy_reg, oe_reg, par_reg, paroe_reg;
   logic        req_reg, hold_reg, wr_reg, lock_reg;
   logic [2:0]  wait_reg;

   wire granted   = ~link.master_grant_n[0];
   wire xfer_done = ~link.trdy_n & irdy_reg;
   wire stopped   = ~link.stop_n & irdy_reg;
   // No target claimed the cycle in time: end it as a master abort.
   wire no_claim  = link.devsel_n & (wait_reg == ABORT_WAIT);

   assign link.ad_far        = ad_reg;
   assign link.ad_far_oe     = oe_reg & wr_reg | (state_reg == F_ADDR);
   assign link.cbe_far       = cbe_reg;
   assign link.cbe_far_oe    = oe_reg;
   assign link.frame_n       = ~frame_reg;
   assign link.irdy_n        = ~irdy_reg;
   assign link.far_oe        = oe_reg;
   assign link.lock_n        = ~lock_reg;
   assign link.par_far       = par_reg;
   assign link.par_far_oe    = paroe_reg;
   assign link.req_n         = {4'hf, ~req_reg};
   assign link.bridge_hold_req_n = ~hold_reg;
   assign link.clkrun_far_oe = 1'b0;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= F_IDLE;
         {ad_reg, cbe_reg} <= '0;
         {frame_reg, irdy_reg, oe_reg, par_reg, paroe_reg} <= '0;
         {req_reg, hold_reg, wr_reg, done, aborted, hold_owned} <= '0;
         rdata <= '0;
         {lock_reg, wait_reg} <= '0;
      end else if (ce) begin
         done <= 1'b0;
         aborted <= 1'b0;
         hold_reg <= hold_want;                                    // RL10
         hold_owned <= hold_reg & ~link.bridge_hold_ack_n;
         paroe_reg <= oe_reg & (wr_reg | state_reg == F_ADDR);     // RL11
         par_reg <= even_par(ad_reg, cbe_reg) ^ par_flip;          // RL11
         unique case (state_reg)
            F_IDLE: if (start) begin
               req_reg <= 1'b1;                                    // RL8
               wr_reg <= write;
               state_reg <= F_REQ;
            end
            F_REQ: if (granted && link.frame_n && link.irdy_n) begin
               req_reg <= 1'b0;
               frame_reg <= 1'b1;                                  // RL3
               oe_reg <= 1'b1;
               ad_reg <= addr;                                     // RL1
               cbe_reg <= wr_reg ? CMD_MEM_WRITE : CMD_MEM_READ;   // RL2
               lock_reg <= lock_want;                              // RL7
               state_reg <= F_ADDR;
            end
            F_ADDR: begin
               frame_reg <= 1'b0;                                  // RL3
               irdy_reg <= 1'b1;                                   // RL5
               ad_reg <= wdata;                                    // RL1
               cbe_reg <= ~byte_en;                                // RL2
               wait_reg <= '0;
               state_reg <= F_DATA;
            end
            F_DATA: if (xfer_done || stopped || no_claim) begin    // RL6
               if (!wr_reg && xfer_done) rdata <= link.ad_host;
               done <= xfer_done;
               aborted <= ~xfer_done;
               irdy_reg <= 1'b0;
               oe_reg <= 1'b0;
               lock_reg <= 1'b0;
               state_reg <= F_TURN;
            end else begin
               wait_reg <= wait_reg + 3'h1;
            end
            F_TURN: state_reg <= F_IDLE;
            default: state_reg <= F_IDLE;
         endcase
      end
   end
endmodule

//--- hdl/pci_host_side_port.sv
// Host-side PCI port: DRAM target, five-way arbiter and hold handshake.
//
// Operation
// [RL1] Address with frame, data in later clocks.
// [RL2] Command with frame, then byte enables.
// [RL3] Frame marks address; release means last.
// [RL4] Claim DRAM cycles with medium devsel timing.
// [RL5] Ready only when data can move.
// [RL6] Target stop ends the master's transaction.
// [RL7] Lock only for processor cycles.
// [RL8] Five requests in, five grants out.
// [RL9] Drain buffers, own host bus, then acknowledge.
// [RL10] Hold handshake supports passive release.
// [RL11] One parity bit over address and command.
// [RL12] Assert system error on detected error.
// [RL13] Open-drain clock-run requests running clock.
// [RL14] Release clock-run after reset deasserts.
// [RL15] Reset is asynchronous; outputs go high impedance. The grants and the hold acknowledge are driven high instead.
// [RL16] Everything runs on the PCI clock.
// [RL17] One grant or hold acknowledge at once.
`timescale 1ns/1ps
module pci_host_side_port
   import pci_port_pkg::*;
#(
   parameter int MEM_WORDS = 16
)(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   input  wire logic        wbuf_pending,
   input  wire logic        post_pending,
   input  wire logic        host_bus_free,
   input  wire logic        cpu_lock,
   input  wire logic        clk_keep,
   output logic             serr_event,
   output logic             locked_reject,
   pci_link_if.host         link
);
   localparam int IDX_W = $clog2(MEM_WORDS);
   if (MEM_WORDS < 2 || MEM_WORDS > 1024 ||
       (MEM_WORDS & (MEM_WORDS - 1)) != 0) begin : g_bad_words
      $error("MEM_WORDS must be a power of two from 2 to 1024");
   end

   typedef enum logic [2:0] {T_IDLE, T_DECODE, T_CLAIM, T_DATA, T_TURN}
      tgt_e;
   typedef enum logic [1:0] {H_IDLE, H_DRAIN, H_ACK} hold_e;

   logic [31:0] mem [MEM_WORDS];
   tgt_e        tstate_reg;
   hold_e       hstate_reg;
   logic [31:0] addr_reg, ad_out_reg;
   logic        wr_reg, devsel_reg, trdy_reg, stop_reg, toe_reg;
   logic        adoe_reg, par_reg, paroe_reg, perr_chk_reg;
   logic [31:0] par_ad_reg;
   logic [3:0]  par_cbe_reg, drain_reg, clkrun_cnt_reg;
   logic [4:0]  grant_reg;
   logic        ack_reg, serr_reg, serr_oe_reg, clkrun_reg, rst_seen_reg;

   wire bus_idle  = link.frame_n & link.irdy_n;
   wire hit_dram  = link.ad_far >= DRAM_BASE && link.ad_far <= DRAM_LIMIT;
   wire is_mem    = link.cbe_far == CMD_MEM_READ ||
                    link.cbe_far == CMD_MEM_WRITE;
   wire pci_lock  = ~link.lock_n & ~cpu_lock;
   wire [IDX_W-1:0] idx = addr_reg[IDX_W+1:2];
   wire [4:0] req = ~link.req_n;
   wire hold_req  = ~link.bridge_hold_req_n;
   wire mem_we    = tstate_reg == T_DATA && !link.irdy_n && wr_reg;
   wire drained   = ~wbuf_pending & ~post_pending & host_bus_free
                    & (drain_reg == '0);

   function automatic logic [4:0] pick(input logic [4:0] r);
      logic [4:0] g;
      g = '0;
      for (int i = NUM_REQ - 1; i >= 0; i--) begin
         if (r[i]) g = 5'h01 << i;
      end
      return g;
   endfunction

   assign link.ad_host        = ad_out_reg;
   assign link.ad_host_oe     = adoe_reg;
   assign link.devsel_n       = ~devsel_reg;
   assign link.trdy_n         = ~trdy_reg;
   assign link.stop_n         = ~stop_reg;
   assign link.tgt_oe         = toe_reg;
   assign link.par_host       = par_reg;
   assign link.par_host_oe    = paroe_reg;
   assign link.master_grant_n = ~grant_reg;
   assign link.bridge_hold_ack_n = ~ack_reg;
   assign link.serr_n         = ~serr_reg;
   assign link.serr_oe        = serr_oe_reg;
   assign link.clkrun_host_oe = clkrun_reg;

   // Target: decode in the address clock, claim two clocks later (medium).
   always_ff @(posedge mclk or negedge rst_b) begin                // RL16
      if (!rst_b) begin                                            // RL15
         tstate_reg <= T_IDLE;
         {addr_reg, ad_out_reg} <= '0;
         {wr_reg, devsel_reg, trdy_reg, stop_reg, toe_reg} <= '0;
         {adoe_reg, locked_reject} <= '0;
      end else if (ce) begin
         locked_reject <= 1'b0;
         unique case (tstate_reg)
            T_IDLE: if (!link.frame_n) begin                       // RL3
               addr_reg <= link.ad_far;                            // RL1
               wr_reg <= link.cbe_far == CMD_MEM_WRITE;            // RL2
               locked_reject <= pci_lock;                          // RL7
               tstate_reg <= (hit_dram && is_mem && !pci_lock)
                             ? T_DECODE : T_TURN;
            end
            T_DECODE: begin
               devsel_reg <= 1'b1;                                 // RL4
               toe_reg <= 1'b1;
               tstate_reg <= T_CLAIM;
            end
            T_CLAIM: begin
               trdy_reg <= 1'b1;                                   // RL5
               stop_reg <= 1'b1;                                   // RL6
               adoe_reg <= ~wr_reg;
               ad_out_reg <= mem[idx];
               tstate_reg <= T_DATA;
            end
            T_DATA: if (!link.irdy_n) begin                        // RL5
               {devsel_reg, trdy_reg, stop_reg, adoe_reg} <= '0;
               tstate_reg <= T_TURN;
            end
            T_TURN: begin
               toe_reg <= 1'b0;
               if (link.frame_n) tstate_reg <= T_IDLE;
            end
            default: tstate_reg <= T_IDLE;
         endcase
      end
   end

   // The model memory keeps its contents across reset, as DRAM would.
   always_ff @(posedge mclk) begin
      if (ce && mem_we) begin
         for (int b = 0; b < CBE_W; b++) begin
            if (!link.cbe_far[b])
               mem[idx][8*b +: 8] <= link.ad_far[8*b +: 8];
         end
      end
   end

   // Parity follows the driven data by one clock; incoming parity is checked for the address phase only.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         {par_reg, paroe_reg, perr_chk_reg} <= '0;
         {par_ad_reg, par_cbe_reg} <= '0;
         {serr_reg, serr_oe_reg, serr_event} <= '0;
      end else if (ce) begin
         par_reg <= even_par(ad_out_reg, link.cbe_far);            // RL11
         paroe_reg <= adoe_reg;
         par_ad_reg <= link.ad_far;
         par_cbe_reg <= link.cbe_far;
         perr_chk_reg <= ~link.frame_n & tstate_reg == T_IDLE;
         serr_event <= perr_chk_reg &&
                       even_par(par_ad_reg, par_cbe_reg) != link.par_far;
         serr_reg <= serr_event;                                   // RL12
         serr_oe_reg <= serr_event;
      end
   end

   // Arbiter and hold handshake share one grant vector.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         hstate_reg <= H_IDLE;
         {grant_reg, ack_reg} <= '0;
         drain_reg <= '0;
      end else if (ce) begin
         unique case (hstate_reg)
            H_IDLE: begin
               if (hold_req && bus_idle) begin                     // RL17
                  grant_reg <= '0;
                  drain_reg <= DRAIN_CYCLES;
                  hstate_reg <= H_DRAIN;
               end else if (bus_idle && (grant_reg & req) == '0) begin
                  grant_reg <= pick(req);                          // RL8
               end
            end
            H_DRAIN: begin
               if (drain_reg != '0) drain_reg <= drain_reg - 4'h1;
               if (!hold_req) hstate_reg <= H_IDLE;
               else if (drained) begin                             // RL9
                  ack_reg <= 1'b1;
                  hstate_reg <= H_ACK;
               end
            end
            H_ACK: if (!hold_req) begin                            // RL10
               ack_reg <= 1'b0;
               hstate_reg <= H_IDLE;
            end
            default: hstate_reg <= H_IDLE;
         endcase
      end
   end

   // Clock-run: asserted while busy or asked; released after reset.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         {clkrun_reg, rst_seen_reg} <= '0;                         // RL14
         clkrun_cnt_reg <= '0;
      end else if (ce) begin
         rst_seen_reg <= 1'b1;
         if (clk_keep || tstate_reg != T_IDLE || hold_req)
            clkrun_cnt_reg <= CLKRUN_HOLD;
         else if (clkrun_cnt_reg != '0)
            clkrun_cnt_reg <= clkrun_cnt_reg - 4'h1;
         clkrun_reg <= rst_seen_reg & (clkrun_cnt_reg != '0);      // RL13
      end
   end
endmodule

//--- verif/pci_link_checker.sv
// Assertions on the link between the host-side port and its far end.
`timescale 1ns/1ps
module pci_link_checker (
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic        frame_n,
   input wire logic        irdy_n,
   input wire logic        devsel_n,
   input wire logic        trdy_n,
   input wire logic        stop_n,
   input wire logic        serr_n,
   input wire logic [31:0] ad_host,
   input wire logic [3:0]  cbe_far,
   input wire logic        par_host,
   input wire logic        par_host_oe,
   input wire logic [4:0]  master_grant_n,
   input wire logic        bridge_hold_req_n,
   input wire logic        bridge_hold_ack_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence claim_s;
      !devsel_n ##1 (!trdy_n && !stop_n);
   endsequence
   sequence release_s;
      !irdy_n ##1 (devsel_n && trdy_n && stop_n);
   endsequence
   AST_DEVSEL_MEDIUM: assert property (
      $fell(devsel_n) |-> $past(frame_n, 2) == 1'b0)
      else $error("devsel not at medium decode time");
   AST_CLAIM_WALK: assert property ($fell(devsel_n) |-> claim_s)
      else $error("trdy did not follow devsel");
   AST_STOP_WITH_TRDY: assert property (!trdy_n |-> !stop_n)
      else $error("data phase without disconnect");
   AST_PHASE_END: assert property ($fell(trdy_n) |-> release_s)
      else $error("target signals not released after data");
   AST_ONE_GRANT: assert property (
      $countones({~master_grant_n, ~bridge_hold_ack_n}) <= 1)
      else $error("more than one grant");
   AST_DRAIN_FIRST: assert property (
      $fell(bridge_hold_ack_n) |-> $past(bridge_hold_req_n, 4) == 1'b0)
      else $error("hold acknowledged without drain time");
   AST_PASSIVE_REL: assert property (
      $rose(bridge_hold_req_n) |=> bridge_hold_ack_n)
      else $error("hold acknowledge not released");
   AST_PARITY: assert property (par_host_oe |->
      par_host == ^{$past(ad_host), $past(cbe_far)})
      else $error("parity wrong");
   AST_SERR_PULSE: assert property (!serr_n |->
      ($past(frame_n, 3) == 1'b0) ##1 serr_n)
      else $error("system error not a pulse after address");
endmodule

//--- verif/testbench.sv
// Bench joining the host-side port to its far-end agent.
`timescale 1ns/1ps
module testbench;
   import pci_port_pkg::*;
   logic        mclk, rst_b, ce, start, write, hold_want, clk_keep;
   logic        lock_want, par_flip;
   logic        wbuf_pending, post_pending, host_bus_free, cpu_lock;
   logic        done, aborted, hold_owned, serr_event, locked_reject;
   logic [31:0] addr, wdata, rdata;
   logic [3:0]  byte_en;
   int          fails, n_checks;
   int          n_reject, n_serr, n_serr_pin;
   pci_link_if link ();
   pci_host_side_port u_pci_host_side_port (.mclk(mclk), .rst_b(rst_b),
      .ce(ce), .wbuf_pending(wbuf_pending), .post_pending(post_pending),
      .host_bus_free(host_bus_free), .cpu_lock(cpu_lock),
      .clk_keep(clk_keep), .serr_event(serr_event),
      .locked_reject(locked_reject), .link(link));
   pci_far_agent u_pci_far_agent (.mclk(mclk), .rst_b(rst_b), .ce(ce),
      .start(start), .write(write), .addr(addr), .wdata(wdata),
      .byte_en(byte_en), .hold_want(hold_want), .done(done),
      .lock_want(lock_want), .par_flip(par_flip),
      .aborted(aborted), .rdata(rdata), .hold_owned(hold_owned),
      .link(link));
   pci_link_checker u_pci_link_checker (.mclk(mclk), .rst_b(rst_b),
      .frame_n(link.frame_n), .irdy_n(link.irdy_n),
      .devsel_n(link.devsel_n), .trdy_n(link.trdy_n),
      .stop_n(link.stop_n), .serr_n(link.serr_n),
      .ad_host(link.ad_host), .cbe_far(link.cbe_far),
      .par_host(link.par_host), .par_host_oe(link.par_host_oe),
      .master_grant_n(link.master_grant_n),
      .bridge_hold_req_n(link.bridge_hold_req_n),
      .bridge_hold_ack_n(link.bridge_hold_ack_n));
   task automatic report_and_stop();
      if (fails == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t data %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_ack(input logic lvl);
      for (int i = 0; i < 20; i++) begin
         @(negedge mclk);
         if (link.bridge_hold_ack_n === lvl) break;
      end
   endtask
   task automatic xfer(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic ab);
      @(posedge mclk);
      start <= 1'b1;
      write <= wr;
      addr <= a;
      wdata <= d;
      byte_en <= be;
      @(posedge mclk);
      start <= 1'b0;
      for (int i = 0; i < 40; i++) begin
         @(negedge mclk);
         if (done === 1'b1 || aborted === 1'b1) break;
      end
      chk1(done | aborted, 1'b1);
      ab = aborted;
   endtask
   task automatic t_rw();
      logic ab;
      xfer(1'b1, 32'h0000_0010, 32'h1234_5678, 4'hf, ab);
      chk1(ab, 1'b0);
      xfer(1'b1, 32'h0000_0010, 32'hcafe_beef, 4'h3, ab);
      xfer(1'b0, 32'h0000_0010, 32'h0000_0000, 4'hf, ab);
      chk32(rdata, 32'h1234_beef);
      xfer(1'b1, DRAM_LIMIT & 32'hffff_fffc, 32'h0bad_f00d, 4'hf, ab);
      xfer(1'b0, DRAM_LIMIT & 32'hffff_fffc, 32'h0000_0000, 4'hf, ab);
      chk32(rdata, 32'h0bad_f00d);
      xfer(1'b0, DRAM_LIMIT + 32'h1, 32'h0000_0000, 4'hf, ab);
      chk1(ab, 1'b1);
   endtask
   // Counts the one-cycle error pulses so scenarios can judge them later.
   always @(negedge mclk) begin
      if (locked_reject === 1'b1) n_reject++;
      if (serr_event === 1'b1) n_serr++;
      if (link.serr_n === 1'b0) n_serr_pin++;
   end
   task automatic t_lock_par();
      logic ab;
      @(posedge mclk);
      lock_want <= 1'b1;
      xfer(1'b0, 32'h0000_0010, 32'h0000_0000, 4'hf, ab);
      chk1(ab, 1'b1);
      chk32(n_reject, 32'h1);
      @(posedge mclk);
      cpu_lock <= 1'b1;
      xfer(1'b0, 32'h0000_0010, 32'h0000_0000, 4'hf, ab);
      chk32(rdata, 32'h1234_beef);
      chk32(n_reject, 32'h1);
      @(posedge mclk);
      {lock_want, cpu_lock, par_flip} <= 3'b001;
      xfer(1'b1, 32'h0000_0018, 32'h5555_aaaa, 4'hf, ab);
      @(posedge mclk);
      par_flip <= 1'b0;
      repeat (4) @(negedge mclk);
      chk32(n_serr, 32'h1);
      chk32(n_serr_pin, 32'h1);
   endtask
   task automatic t_freeze();
      @(posedge mclk);
      ce <= 1'b0;
      start <= 1'b1;
      repeat (4) @(negedge mclk);
      chk1(link.req_n[0], 1'b1);
      @(posedge mclk);
      ce <= 1'b1;
      start <= 1'b0;
      repeat (2) @(negedge mclk);
      chk1(link.req_n[0], 1'b1);
   endtask
   task automatic t_hold();
      @(posedge mclk);
      {wbuf_pending, post_pending, host_bus_free} <= 3'b110;
      hold_want <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         repeat (12) @(negedge mclk);
         chk1(link.bridge_hold_ack_n, 1'b1);
         @(posedge mclk);
         if (k == 0) wbuf_pending <= 1'b0;
         else if (k == 1) post_pending <= 1'b0;
         else host_bus_free <= 1'b1;
      end
      wait_ack(1'b0);
      chk1(link.bridge_hold_ack_n, 1'b0);
      chk1(link.master_grant_n === 5'h1f, 1'b1);
      @(negedge mclk);
      chk1(hold_owned, 1'b1);
      @(posedge mclk);
      hold_want <= 1'b0;
      wait_ack(1'b1);
      chk1(link.bridge_hold_ack_n, 1'b1);
      chk1(hold_owned, 1'b0);
   endtask
   task automatic t_clkrun_reset();
      logic ab;
      @(posedge mclk);
      clk_keep <= 1'b1;
      start <= 1'b1;
      write <= 1'b0;
      addr <= 32'h0000_0020;
      repeat (3) @(negedge mclk);
      chk1(link.clkrun_n, 1'b0);
      @(posedge mclk);
      start <= 1'b0;
      rst_b <= 1'b0;
      #1;
      chk1(link.ad_host_oe | link.tgt_oe | link.par_host_oe, 1'b0);
      chk1(link.serr_oe | link.clkrun_host_oe, 1'b0);
      chk1(&{link.master_grant_n, link.bridge_hold_ack_n}, 1'b1);
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      @(negedge mclk);
      chk1(link.clkrun_host_oe, 1'b0);
      @(posedge mclk);
      clk_keep <= 1'b0;
      repeat (CLKRUN_HOLD + 4) @(negedge mclk);
      chk1(link.clkrun_n, 1'b1);
      xfer(1'b0, 32'h0000_0010, 32'h0000_0000, 4'hf, ab);
      chk32(rdata, 32'h1234_beef);
   endtask
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      {fails, n_checks} = '0;
      {rst_b, start, write, hold_want, clk_keep, cpu_lock} = '0;
      {ce, wbuf_pending, post_pending, host_bus_free} = 4'hd;
      {lock_want, par_flip} = '0;
      {n_reject, n_serr, n_serr_pin} = '0;
      {addr, wdata, byte_en} = '0;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      t_rw();
      t_lock_par();
      t_freeze();
      t_hold();
      t_clkrun_reset();
      report_and_stop();
   end
   // The tests need well under a thousand cycles; five thousand is a hang.
   initial begin
      repeat (5000) @(posedge mclk);
      fails++;
      report_and_stop();
   end
endmodule
